// ==== hw/cpu_map_pkg.sv ====
// constants, field positions and carrier types for the core address map and register set
package cpu_map_pkg;

	// address layout
	localparam int ADDR_W      = 32;
	localparam int PHYS_W      = 24;           // bits driven to the outside
	localparam int BLK_W       = 2;            // four 1-Gbyte blocks per space
	localparam int BLK_LSB     = 30;
	localparam int BLK_MSB     = 31;
	localparam int ALIAS_LSB   = 24;           // bits 29..24 select an image only
	localparam int ALIAS_MSB   = 29;
	localparam int NUM_BLOCKS  = 4;
	localparam logic [1:0] INT_IO_BLOCK = 2'h3; // I/O block 3 stays on chip
	localparam logic [3:0] CS_NONE      = 4'hF;

	// register set
	localparam int DATA_W      = 32;
	localparam int BYTE_W      = 8;
	localparam int BYTES_W     = 4;
	localparam int NUM_GPR     = 32;
	localparam int IDX_W       = 5;
	localparam logic [4:0] GPR_ZERO    = 5'h00;
	localparam logic [4:0] STR_DST_OFS = 5'h1A;
	localparam logic [4:0] STR_SRC_OFS = 5'h1B;
	localparam logic [4:0] STR_LEN     = 5'h1C;
	localparam logic [4:0] STR_DST_ADR = 5'h1D;
	localparam logic [4:0] STR_SRC_ADR = 5'h1E;
	localparam logic [4:0] LINK_REG    = 5'h1F;
	localparam int PC_ALIGN_BIT = 0;
	localparam logic [31:0] RESET_VECTOR = 32'hFFFFFFF0;

	// system register numbers
	localparam logic [4:0] SR_SAVED_PC     = 5'h00;
	localparam logic [4:0] SR_SAVED_STATUS = 5'h01;
	localparam logic [4:0] SR_CAUSE        = 5'h04;
	localparam int CAUSE_W   = 16;
	localparam int CAUSE_HI  = 16;             // fatal code starts at this bit

	// one access request from the execution pipeline
	typedef struct packed {
		logic              valid;
		logic              io;                 // 1: I/O space, 0: memory space
		logic              read;
		logic [ADDR_W-1:0] addr;
	} acc_req_type;

	// external address phase
	typedef struct packed {
		logic              valid;
		logic              read;
		logic              int_io;             // on-chip peripheral select
		logic [3:0]        mem_cs_n;
		logic [3:0]        io_cs_n;
		logic [PHYS_W-1:0] addr;
	} ext_bus_type;

	// exception or interrupt being taken
	typedef struct packed {
		logic               take;
		logic               fatal;             // non-maskable or double exception
		logic [CAUSE_W-1:0] code;
		logic [DATA_W-1:0]  status;
	} exc_req_type;

	// operands implicitly used by bit-string instructions
	typedef struct packed {
		logic [DATA_W-1:0] dst_ofs;
		logic [DATA_W-1:0] src_ofs;
		logic [DATA_W-1:0] len;
		logic [DATA_W-1:0] dst_addr;
		logic [DATA_W-1:0] src_addr;
	} string_regs_type;

endpackage : cpu_map_pkg

// ==== hw/cpu_addr_map_regfile.sv ====
// core address mapper, load/interrupt arbitration and architectural registers
`timescale 1ns/1ps
`default_nettype none

// Contract
// RULE1: only the low 24 address bits leave the core.
// RULE2: each space has four 1-Gbyte blocks, each with its own chip select.
// RULE3: address bits 29..24 are ignored, giving 64 images of 16 Mbytes.
// RULE4: I/O block 3 is internal peripheral space, no external select.
// RULE5: interrupt during a memory load wins; load is dropped for retry.
// RULE6: interrupt during an I/O read waits; read completes, never reissued.
// RULE7: read-sensitive external devices must sit in I/O space.
// RULE8: thirty-two 32-bit general registers plus a separate program counter.
// RULE9: register zero always reads zero.
// RULE10: program counter bit 0 is always zero.
// RULE11: reset loads the program counter with the reset vector.
// RULE12: registers 26..30 feed bit-string operands in fixed order.
// RULE13: jump-and-link writes the return address into register 31.
// RULE14: multi-byte data is little-endian.
// RULE15: one saved pc/status pair captures state on exception or interrupt.
// RULE16: cause register: fatal code high half, ordinary code low half.
module cpu_addr_map_regfile
	import cpu_map_pkg::*;
#(
	parameter logic [31:0] RESET_VEC = RESET_VECTOR
) (
	input  wire logic                        clk_i,       // core clock
	input  wire logic                        resetn_i,    // async, active low
	input  wire acc_req_type                 acc_i,       // access request
	input  wire logic [BYTES_W-1:0][BYTE_W-1:0] ld_bytes_i, // [n] = addr+n
	input  wire logic                        ext_done_i,  // read data valid
	input  wire logic                        irq_i,       // interrupt pending
	output ext_bus_type                      ext_o,       // address phase
	output logic [DATA_W-1:0]                ld_word_o,   // assembled load
	output logic                             ld_valid_o,  // load done pulse
	output logic                             ld_retry_o,  // load dropped pulse
	output logic                             irq_take_o,  // irq accepted pulse
	input  wire logic [IDX_W-1:0]            rd_a_idx_i,  // read port a index
	input  wire logic [IDX_W-1:0]            rd_b_idx_i,  // read port b index
	output logic [DATA_W-1:0]                rd_a_data_o, // read port a data
	output logic [DATA_W-1:0]                rd_b_data_o, // read port b data
	input  wire logic                        wr_en_i,     // gpr write strobe
	input  wire logic [IDX_W-1:0]            wr_idx_i,    // gpr write index
	input  wire logic [DATA_W-1:0]           wr_data_i,   // gpr write data
	input  wire logic                        jal_i,       // jump-and-link
	input  wire logic [DATA_W-1:0]           link_addr_i, // return address
	output string_regs_type                  str_regs_o,  // bit-string regs
	input  wire logic                        pc_load_i,   // branch/advance
	input  wire logic [DATA_W-1:0]           pc_target_i, // next pc
	output logic [DATA_W-1:0]                pc_o,        // program counter
	input  wire exc_req_type                 exc_i,       // exception taken
	input  wire logic                        sr_we_i,     // sysreg write
	input  wire logic [IDX_W-1:0]            sr_idx_i,    // sysreg number
	input  wire logic [DATA_W-1:0]           sr_wdata_i,  // sysreg write data
	output logic [DATA_W-1:0]                sr_rdata_o   // sysreg read data
);

	// the reset vector must be a legal even fetch address
	if (RESET_VEC[PC_ALIGN_BIT] != 1'b0) begin : g_bad_vec
		$error("reset vector must be even");
	end

	typedef enum logic [1:0] {RD_IDLE, RD_MEM, RD_IO} rd_state_type;

	rd_state_type         rd_q, rd_d;
	ext_bus_type          ext_q, ext_d, dec_bus;
	logic [DATA_W-1:0]    ld_word_q, ld_word_d;
	logic                 ld_valid_q, ld_valid_d;
	logic                 retry_q, retry_d;
	logic                 irq_take_q, irq_take_d;
	logic                 acc_take;
	logic [BLK_W-1:0]     blk;
	logic [DATA_W-1:0]    gpr_q [NUM_GPR];
	logic [DATA_W-1:0]    gpr_d [NUM_GPR];
	logic [DATA_W-1:0]    rd_a_q, rd_a_d, rd_b_q, rd_b_d;
	logic [DATA_W-1:0]    pc_q, pc_d;
	logic [DATA_W-1:0]    spc_q, spc_d, sst_q, sst_d, cause_q, cause_d;
	logic [DATA_W-1:0]    sr_rd_q, sr_rd_d;

	// address decode: block from the top bits, image bits simply dropped
	always_comb begin
		blk              = acc_i.addr[BLK_MSB:BLK_LSB];           // [RULE2]
		dec_bus          = '0;
		dec_bus.valid    = 1'b1;
		dec_bus.read     = acc_i.read;
		dec_bus.addr     = acc_i.addr[PHYS_W-1:0];          // [RULE1] [RULE3]
		dec_bus.mem_cs_n = CS_NONE;
		dec_bus.io_cs_n  = CS_NONE;
		if (!acc_i.io) begin
			dec_bus.mem_cs_n[blk] = 1'b0;                         // [RULE2]
		end else if (blk == INT_IO_BLOCK) begin
			dec_bus.int_io = 1'b1;                                // [RULE4]
		end else begin
			dec_bus.io_cs_n[blk] = 1'b0;                          // [RULE2]
		end
	end

	// an access is accepted only when idle and no interrupt is being taken
	assign acc_take = (rd_q == RD_IDLE) && acc_i.valid && !irq_i;

	// read sequencer: memory loads yield to interrupts, I/O reads do not
	always_comb begin
		rd_d       = rd_q;
		ext_d      = ext_q;
		ld_word_d  = ld_word_q;
		ld_valid_d = 1'b0;
		retry_d    = 1'b0;
		irq_take_d = 1'b0;
		case (rd_q)
			RD_IDLE: begin
				ext_d.valid = 1'b0;
				if (irq_i) begin
					irq_take_d = !irq_take_q;
				end else if (acc_i.valid) begin
					ext_d = dec_bus;
					if (acc_i.read) begin
						rd_d = acc_i.io ? RD_IO : RD_MEM;
					end
				end
			end
			RD_MEM: begin
				if (irq_i) begin
					// data may already be on the bus; dropping it is safe
					// only because memory-space reads have no side effect
					rd_d        = RD_IDLE;                        // [RULE5]
					ext_d.valid = 1'b0;
					retry_d     = 1'b1;                           // [RULE5]
					irq_take_d  = !irq_take_q;                    // [RULE5]
				end else if (ext_done_i) begin
					rd_d        = RD_IDLE;
					ext_d.valid = 1'b0;
					ld_valid_d  = 1'b1;
					ld_word_d   = {ld_bytes_i[3], ld_bytes_i[2],
						ld_bytes_i[1], ld_bytes_i[0]};            // [RULE14]
				end
			end
			RD_IO: begin
				// the interrupt is held off so a clear-on-read device is
				// never read twice
				if (ext_done_i) begin
					rd_d        = RD_IDLE;                        // [RULE6]
					ext_d.valid = 1'b0;
					ld_valid_d  = 1'b1;
					ld_word_d   = {ld_bytes_i[3], ld_bytes_i[2],
						ld_bytes_i[1], ld_bytes_i[0]};            // [RULE14]
					irq_take_d  = irq_i && !irq_take_q;           // [RULE6]
				end
			end
			default: begin
				rd_d        = RD_IDLE;
				ext_d.valid = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rd_q       <= RD_IDLE;
			ext_q      <= '{valid: 1'b0, read: 1'b0, int_io: 1'b0,
				mem_cs_n: CS_NONE, io_cs_n: CS_NONE, addr: '0};
			ld_word_q  <= '0;
			ld_valid_q <= 1'b0;
			retry_q    <= 1'b0;
			irq_take_q <= 1'b0;
		end else begin
			rd_q       <= rd_d;
			ext_q      <= ext_d;
			ld_word_q  <= ld_word_d;
			ld_valid_q <= ld_valid_d;
			retry_q    <= retry_d;
			irq_take_q <= irq_take_d;
		end
	end

	assign ext_o      = ext_q;
	assign ld_word_o  = ld_word_q;
	assign ld_valid_o = ld_valid_q;
	assign ld_retry_o = retry_q;
	assign irq_take_o = irq_take_q;

	// general registers; link write lands after the port write so it wins
	always_comb begin
		gpr_d = gpr_q;
		if (wr_en_i) begin
			gpr_d[wr_idx_i] = wr_data_i;                          // [RULE8]
		end
		if (jal_i) begin
			gpr_d[LINK_REG] = link_addr_i;                        // [RULE13]
		end
		gpr_d[GPR_ZERO] = '0;                                     // [RULE9]
		rd_a_d = (rd_a_idx_i == GPR_ZERO) ? '0 : gpr_q[rd_a_idx_i]; // [RULE9]
		rd_b_d = (rd_b_idx_i == GPR_ZERO) ? '0 : gpr_q[rd_b_idx_i]; // [RULE9]
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			for (int i = 0; i < NUM_GPR; i++) begin
				gpr_q[i] <= '0;
			end
			rd_a_q <= '0;
			rd_b_q <= '0;
		end else begin
			for (int i = 0; i < NUM_GPR; i++) begin
				gpr_q[i] <= gpr_d[i];
			end
			rd_a_q <= rd_a_d;
			rd_b_q <= rd_b_d;
		end
	end

	assign rd_a_data_o = rd_a_q;
	assign rd_b_data_o = rd_b_q;

	// bit-string operands come straight from their fixed registers
	assign str_regs_o.dst_ofs  = gpr_q[STR_DST_OFS];              // [RULE12]
	assign str_regs_o.src_ofs  = gpr_q[STR_SRC_OFS];              // [RULE12]
	assign str_regs_o.len      = gpr_q[STR_LEN];                  // [RULE12]
	assign str_regs_o.dst_addr = gpr_q[STR_DST_ADR];              // [RULE12]
	assign str_regs_o.src_addr = gpr_q[STR_SRC_ADR];              // [RULE12]

	// program counter, low bit forced clear on every load
	always_comb begin
		pc_d = pc_q;
		if (pc_load_i) begin
			pc_d = pc_target_i;
		end
		pc_d[PC_ALIGN_BIT] = 1'b0;                                // [RULE10]
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pc_q <= RESET_VEC;                                    // [RULE11]
		end else begin
			pc_q <= pc_d;
		end
	end

	assign pc_o = pc_q;

	// system registers; a hardware capture overrides a same-cycle write
	always_comb begin
		spc_d   = spc_q;
		sst_d   = sst_q;
		cause_d = cause_q;
		if (sr_we_i && (sr_idx_i == SR_SAVED_PC)) begin
			spc_d = sr_wdata_i;
		end
		if (sr_we_i && (sr_idx_i == SR_SAVED_STATUS)) begin
			sst_d = sr_wdata_i;
		end
		// a single pair: a nested capture overwrites the older state
		if (exc_i.take) begin
			spc_d = pc_q;                                         // [RULE15]
			sst_d = exc_i.status;                                 // [RULE15]
			if (exc_i.fatal) begin
				cause_d[DATA_W-1:CAUSE_HI] = exc_i.code;          // [RULE16]
			end else begin
				cause_d[CAUSE_W-1:0] = exc_i.code;                // [RULE16]
			end
		end
		case (sr_idx_i)
			SR_SAVED_PC:     sr_rd_d = spc_q;
			SR_SAVED_STATUS: sr_rd_d = sst_q;
			SR_CAUSE:        sr_rd_d = cause_q;
			default:         sr_rd_d = '0;
		endcase
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			spc_q   <= '0;
			sst_q   <= '0;
			cause_q <= '0;
			sr_rd_q <= '0;
		end else begin
			spc_q   <= spc_d;
			sst_q   <= sst_d;
			cause_q <= cause_d;
			sr_rd_q <= sr_rd_d;
		end
	end

	assign sr_rdata_o = sr_rd_q;

	// checks on the behaviour above
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!resetn_i);

	phys_addr_a: assert property (acc_take |=> // [RULE1]
		ext_o.addr == $past(acc_i.addr[PHYS_W-1:0]) && ext_o.valid)
		else $error("external address not the low 24 bits");
	one_select_a: assert property (ext_o.valid && !ext_o.int_io |-> // [RULE2]
		$countones(~{ext_o.mem_cs_n, ext_o.io_cs_n}) == 1)
		else $error("not exactly one chip select active");
	image_block_a: assert property (acc_take && !acc_i.io |=> // [RULE3]
		!ext_o.mem_cs_n[$past(acc_i.addr[BLK_MSB:BLK_LSB])])
		else $error("memory block select wrong");
	int_io_a: assert property (acc_take && acc_i.io && // [RULE4]
		acc_i.addr[BLK_MSB:BLK_LSB] == INT_IO_BLOCK |=>
		ext_o.int_io && ext_o.io_cs_n == CS_NONE)
		else $error("internal I/O block decoded externally");
	mem_abort_a: assert property (rd_q == RD_MEM && irq_i |=> // [RULE5]
		ld_retry_o && !ld_valid_o && rd_q == RD_IDLE)
		else $error("memory load not dropped on interrupt");
	io_hold_a: assert property (rd_q == RD_IO && !ext_done_i |=> // [RULE6]
		!irq_take_o && !ld_retry_o)
		else $error("interrupt taken inside an I/O read");
	io_done_a: assert property (rd_q == RD_IO && ext_done_i |=> // [RULE6]
		ld_valid_o ##1 !ld_retry_o)
		else $error("I/O read not completed");
	zero_reg_a: assert property (rd_a_idx_i == GPR_ZERO |=> // [RULE9]
		rd_a_data_o == '0)
		else $error("register zero read non-zero");
	pc_load_a: assert property (pc_load_i |=> // [RULE10]
		pc_o == {$past(pc_target_i[DATA_W-1:1]), 1'b0})
		else $error("pc load wrong or odd");
	link_reg_a: assert property (jal_i |=> // [RULE13]
		gpr_q[LINK_REG] == $past(link_addr_i))
		else $error("link address not in register 31");
	capture_a: assert property (exc_i.take |=> // [RULE15]
		spc_q == $past(pc_o) && sst_q == $past(exc_i.status))
		else $error("saved pc or status not captured");
	cause_split_a: assert property (exc_i.take && exc_i.fatal |=> // [RULE16]
		cause_q[DATA_W-1:CAUSE_HI] == $past(exc_i.code) &&
		cause_q[CAUSE_W-1:0] == $past(cause_q[CAUSE_W-1:0]))
		else $error("fatal cause not in upper half");

	mem_load_c: cover property (rd_q == RD_MEM && ext_done_i && !irq_i);
	mem_abort_c: cover property (rd_q == RD_MEM && irq_i);
	io_irq_c: cover property (rd_q == RD_IO && irq_i ##1 ext_done_i);
	int_io_c: cover property (acc_take && acc_i.io &&
		acc_i.addr[BLK_MSB:BLK_LSB] == INT_IO_BLOCK);

endmodule : cpu_addr_map_regfile

`default_nettype wire

// ==== dv/ext_dev_model.sv ====
// behavioural external memory and I/O devices answering the core's bus
`timescale 1ns/1ps
`default_nettype none
module ext_dev_model
	import cpu_map_pkg::*;
(
	input  wire logic                      clk_i,    // core clock
	input  wire logic                      resetn_i, // async, active low
	input  wire ext_bus_type               ext_i,    // address phase
	input  wire logic [3:0]                wait_i,   // answer delay, cycles
	output logic                           done_o,   // read data valid
	output logic [BYTES_W-1:0][BYTE_W-1:0] bytes_o,  // byte n = addr+n
	output logic [7:0]                     io_rd_o   // completed I/O reads
);
	logic [3:0] cnt;

	// answer a pending read once the programmed wait has run out
	assign done_o = ext_i.valid && ext_i.read && (cnt == wait_i);

	// the read counter is a read-sensitive device, so it lives in I/O space
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cnt     <= 4'h0;
			io_rd_o <= 8'h00;
		end else begin
			if (done_o || !(ext_i.valid && ext_i.read)) begin
				cnt <= 4'h0;
			end else begin
				cnt <= cnt + 4'h1;
			end
			if (done_o && (ext_i.io_cs_n != CS_NONE ||
				ext_i.int_io)) begin
				io_rd_o <= io_rd_o + 8'h01;
			end
		end
	end

	// data lines carry garbage outside the answer cycle, not the last value
	always_comb begin
		for (int n = 0; n < BYTES_W; n++) begin
			bytes_o[n] = ext_i.addr[7:0] + 8'(n);
			if (!done_o) bytes_o[n] = ~bytes_o[n];
		end
	end
endmodule : ext_dev_model
`default_nettype wire

// ==== dv/cpu_addr_map_regfile_tb.sv ====
// self-checking bench for the core address map and register set
`timescale 1ns/1ps
`default_nettype none
module cpu_addr_map_regfile_tb
	import cpu_map_pkg::*;
;
	typedef struct packed {
		logic        io;
		logic [31:0] addr;
		logic [3:0]  mcs;
		logic [3:0]  ics;
		logic        intio;
	} row_type;
	logic            clk_i, resetn_i, irq, wr_en, jump_and_link_instr, pc_ld, sr_we, done;
	logic            vld, rty, tk;
	logic [3:0]      wt;
	logic [4:0]      ra, wr_i, sri;
	logic [31:0]     wr_d, lnk, pc_t, sr_d, word, rda, rdb, pc, srd;
	logic [7:0]      io_rd;
	logic [3:0][7:0] bytes;
	acc_req_type     acc;
	exc_req_type     exc;
	ext_bus_type     ext;
	string_regs_type sreg;
	int              n_errors = 0;
	int              samples_checked = 0;
	int              cycles = 0;
	row_type         rows [8] = '{
		'{1'b0, 32'h00123456, 4'hE, 4'hF, 1'b0},
		'{1'b0, 32'h7FABCDEF, 4'hD, 4'hF, 1'b0},
		'{1'b0, 32'hBE000001, 4'hB, 4'hF, 1'b0},
		'{1'b0, 32'hFFFFFFFF, 4'h7, 4'hF, 1'b0},
		'{1'b1, 32'h01000010, 4'hF, 4'hE, 1'b0},
		'{1'b1, 32'h40FEDCBA, 4'hF, 4'hD, 1'b0},
		'{1'b1, 32'h80000000, 4'hF, 4'hB, 1'b0},
		'{1'b1, 32'hC0000010, 4'hF, 4'hF, 1'b1}};

	cpu_addr_map_regfile cpu_addr_map_regfile_i (.clk_i(clk_i),
		.resetn_i(resetn_i), .acc_i(acc), .ld_bytes_i(bytes),
		.ext_done_i(done), .irq_i(irq), .ext_o(ext), .ld_word_o(word),
		.ld_valid_o(vld), .ld_retry_o(rty), .irq_take_o(tk),
		.rd_a_idx_i(ra), .rd_b_idx_i(ra), .rd_a_data_o(rda),
		.rd_b_data_o(rdb), .wr_en_i(wr_en), .wr_idx_i(wr_i),
		.wr_data_i(wr_d), .jal_i(jump_and_link_instr), .link_addr_i(lnk),
		.str_regs_o(sreg), .pc_load_i(pc_ld), .pc_target_i(pc_t),
		.pc_o(pc), .exc_i(exc), .sr_we_i(sr_we), .sr_idx_i(sri),
		.sr_wdata_i(sr_d), .sr_rdata_o(srd));
	ext_dev_model ext_dev_model_i (.clk_i(clk_i), .resetn_i(resetn_i),
		.ext_i(ext), .wait_i(wt), .done_o(done), .bytes_o(bytes),
		.io_rd_o(io_rd));

	// 200 MHz core clock
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end

	// cut a hang short well beyond the expected run length
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 3000) begin
			n_errors++;
			summarize();
		end
	end

	task automatic check(input string what, input logic [31:0] exp, got);
		samples_checked++;
		if (got !== exp) begin
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
			n_errors++;
		end
	endtask : check

	task automatic summarize();
		$display("checks %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : summarize

	// one access request, held valid for a single clock cycle
	task automatic go(input logic io, rd, input logic [31:0] a);
		@(posedge clk_i);
		acc <= '{1'b1, io, rd, a};
		@(posedge clk_i);
		acc.valid <= 1'b0;
	endtask : go

	// vld and rty are driven by the design, so only watch them here
	task automatic wait_end();
		int k;
		for (k = 0; k < 20 && !(vld || rty); k++) begin
			@(posedge clk_i);
			#1;
		end
	endtask : wait_end

	task automatic wr(input logic [4:0] i, input logic [31:0] d);
		@(posedge clk_i);
		wr_en <= 1'b1;
		wr_i  <= i;
		wr_d  <= d;
	endtask : wr

	// read a general register on both ports, or a system register
	task automatic rd(input logic sys, input logic [4:0] i,
		input logic [31:0] e);
		@(posedge clk_i);
		ra  <= i;
		sri <= i;
		@(posedge clk_i);
		#1;
		if (sys) check("sysreg", e, srd);
		else begin
			check("gpr port a", e, rda);
			check("gpr port b", e, rdb);
		end
	endtask : rd

	initial begin
		{resetn_i, irq, wr_en, jump_and_link_instr, pc_ld, sr_we} = '0;
		{ra, wr_i, sri, wr_d, lnk, pc_t, sr_d} = '0;
		wt  = 4'h0;
		acc = '0;
		exc = '0;
		repeat (3) @(posedge clk_i);
		#1 check("reset pc", RESET_VECTOR, pc);
		check("reset cs", {28'h0, CS_NONE}, {28'h0, ext.mem_cs_n});
		@(posedge clk_i) resetn_i <= 1'b1;
		// decode table: block selects, 24-bit address, images, internal I/O
		foreach (rows[r]) begin
			go(rows[r].io, 1'b0, rows[r].addr);
			#1;
			check("phys addr", {8'h0, rows[r].addr[23:0]},
				{8'h0, ext.addr});
			check("mem cs", {28'h0, rows[r].mcs},
				{28'h0, ext.mem_cs_n});
			check("io cs", {28'h0, rows[r].ics},
				{28'h0, ext.io_cs_n});
			check("int io", {31'h0, rows[r].intio},
				{31'h0, ext.int_io});
			check("valid write", 32'h2,
				{30'h0, ext.valid, ext.read});
		end
		// plain load: bytes assembled lowest address first
		go(1'b0, 1'b1, 32'h40000080);
		wait_end();
		check("load word", 32'h83828180, word);
		// interrupt during a slow memory load drops the load
		@(posedge clk_i) wt <= 4'h3;
		go(1'b0, 1'b1, 32'h00000100);
		irq <= 1'b1;
		wait_end();
		check("retry take", 32'h3, {30'h0, rty, tk});
		@(posedge clk_i) irq <= 1'b0;
		// the dropped load is simply issued again and completes
		go(1'b0, 1'b1, 32'h00000100);
		wait_end();
		check("reissued load", 32'h03020100, word);
		// interrupt during an I/O read waits for the data
		go(1'b1, 1'b1, 32'h00000040);
		irq <= 1'b1;
		wait_end();
		check("io done take", 32'h3, {30'h0, vld, tk});
		check("io word", 32'h43424140, word);
		@(posedge clk_i) irq <= 1'b0;
		repeat (6) @(posedge clk_i);
		check("io reads", 32'h1, {24'h0, io_rd});
		// general registers, r0, string operands, link beats same-index write
		wr(5'h00, 32'hFFFFFFFF);
		wr(5'h07, 32'h12345678);
		for (int i = 26; i < 31; i++) wr(5'(i), 32'hA0 + i);
		wr(5'h1F, 32'hDEAD0000);
		jump_and_link_instr <= 1'b1;
		lnk <= 32'h00001000;
		@(posedge clk_i);
		{wr_en, jump_and_link_instr} <= 2'b00;
		rd(1'b0, 5'h00, 32'h0);
		rd(1'b0, 5'h07, 32'h12345678);
		rd(1'b0, 5'h1F, 32'h00001000);
		check("string regs", 32'h0,
			(sreg === {32'hBA, 32'hBB, 32'hBC, 32'hBD, 32'hBE}) ?
			32'h0 : 32'h1);
		// odd branch target lands even
		@(posedge clk_i);
		pc_ld <= 1'b1;
		pc_t  <= 32'h00002001;
		@(posedge clk_i) pc_ld <= 1'b0;
		#1 check("pc", 32'h00002000, pc);
		// two captures back to back, first against a software write
		@(posedge clk_i);
		exc   <= '{1'b1, 1'b0, 16'h0040, 32'h0000ABCD};
		sr_we <= 1'b1;
		sri   <= SR_SAVED_PC;
		sr_d  <= 32'h55555555;
		@(posedge clk_i);
		exc   <= '{1'b1, 1'b1, 16'hFFD0, 32'h0000ABCD};
		sr_we <= 1'b0;
		@(posedge clk_i) exc.take <= 1'b0;
		rd(1'b1, SR_SAVED_PC, 32'h00002000);
		rd(1'b1, SR_SAVED_STATUS, 32'h0000ABCD);
		rd(1'b1, SR_CAUSE, 32'hFFD00040);
		@(posedge clk_i);
		sr_we <= 1'b1;
		sri   <= SR_SAVED_STATUS;
		sr_d  <= 32'h12345678;
		@(posedge clk_i) sr_we <= 1'b0;
		rd(1'b1, SR_SAVED_STATUS, 32'h12345678);
		// reset in mid-run restores the vector and clears registers
		@(posedge clk_i) resetn_i <= 1'b0;
		@(posedge clk_i);
		#1 check("rerun pc", RESET_VECTOR, pc);
		check("rerun cs", {24'h0, CS_NONE, CS_NONE},
			{24'h0, ext.mem_cs_n, ext.io_cs_n});
		@(posedge clk_i) resetn_i <= 1'b1;
		rd(1'b0, 5'h07, 32'h0);
		summarize();
	end
endmodule : cpu_addr_map_regfile_tb
`default_nettype wire
